// >>> verilog/rtcpi_pkg.sv
// Shared constants, state codes and signal bundles of the RTC pin interface.
// Assumes a 10 MHz core clock and a 32.768 kHz timekeeping source on the oscillator pin.
package rtcpi_pkg;

    // Timekeeping prescaler and seconds counter.
    localparam int unsigned PRESC_W = 15;
    localparam logic [PRESC_W-1:0] PRESC_STEP = 15'h0001;
    localparam logic [PRESC_W-1:0] PRESC_LAST = 15'h7FFF;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 15'h0000;
    localparam int unsigned SECONDS_W = 32;
    localparam logic [SECONDS_W-1:0] SECONDS_RESET = 32'h00000000;
    localparam logic [SECONDS_W-1:0] SECONDS_STEP = 32'h00000001;

    // Serial byte framing; bytes travel most significant bit first.
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned WRITE_FLAG_BIT = 7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

    // Levels of the interface select strap.
    localparam logic MODE_3WIRE = 1'b0;
    localparam logic MODE_SPI = 1'b1;

    // Value that an open-drain interrupt pin carries while it is driven.
    localparam logic IRQ_DRIVE_LEVEL = 1'b0;

    // Transfer sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_WRITE = 4'h4,
        ST_READ = 4'h8
    } rtcpi_state_e;

    // Pin levels that arrive from outside the core clock domain.
    typedef struct packed {
        logic chip_enable;
        logic sclk;
        logic data_in;
        logic below_backup;
        logic below_battery;
        logic osc;
        logic interface_select;
    } rtcpi_pins_s;

    localparam rtcpi_pins_s PINS_RESET = '0;

    // Sticky alarm status flags.
    typedef struct packed {
        logic flag_a;
        logic flag_b;
    } rtcpi_flags_s;

    // Drive-low enables of the two interrupt pins.
    typedef struct packed {
        logic drive_a;
        logic drive_b;
    } rtcpi_irq_s;

    // Shifts one bit into the low end of a byte.
    function automatic logic [BYTE_W-1:0] rtcpi_shift_in(input logic [BYTE_W-1:0] value,
                                                        input logic bit_in);
        return {value[BYTE_W-2:0], bit_in};
    endfunction : rtcpi_shift_in

endpackage : rtcpi_pkg

// >>> verilog/rtcpi_sync.sv
// Two-stage synchroniser for a bundle of independent level signals.
// Assumes each bit is a slow level; multi-bit words are not kept coherent.
module rtcpi_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule : rtcpi_sync

// >>> verilog/rtcpi_edge.sv
// Edge finder for a level that is already synchronous to the core clock.
// Assumes the level stays stable for at least two core clock cycles.
module rtcpi_edge (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Level in, one-cycle edge pulses out.
    input wire logic level_i,
    output logic rise_o,
    output logic fall_o
);

    logic prev;
    logic next_prev;

    // The previous level is simply the present one delayed.
    always_comb begin
        next_prev = level_i;
    end

    // Registers the previous level.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

    // Edges compare the present level with the previous one.
    assign rise_o = level_i & ~prev;
    assign fall_o = ~level_i & prev;

endmodule : rtcpi_edge

// >>> verilog/rtcpi_top.sv
// Pin-level logic of a serial alarm real-time clock: interrupt pins, serial
// interface framing and mode strap, power-fail output and the seconds timebase.
// Assumes the alarm match logic supplies event pulses on the core clock, and that
// the host, chip enable, serial clock and oscillator pins are asynchronous to it.
//
// Function
// (R1) First interrupt serves alarm A, or either alarm.
// (R2) Second interrupt follows alarm B only.
// (R3) Interrupt stays low while flag and enable set.
// (R4) Strap low selects 3-wire, high selects SPI.
// (R5) Host holds chip enable through every transfer.
// (R6) SPI: bits in on data in, out separately.
// (R7) 3-wire shared line; device drives only read data.
// (R8) Host serial clock times all data movement.
// (R9) Power-fail low when primary below backup or battery.
// (R10) Timekeeping counts the 32.768kHz oscillator input.
// (R11) Interrupts and timekeeping ignore the primary supply level.
// (R12) Combine select chooses separate or shared interrupts.
// (R13) Interrupt pins are drive-low enables, else released.
// (R14) Interface select is a strap, held during transfers.
module rtcpi_top (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Serial link pins from the host.
    input wire logic chip_enable_i,
    input wire logic sclk_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    // Interface select strap.
    input wire logic interface_select_i,
    // Received bytes and read data towards the register logic.
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic rx_is_addr_o,
    input wire logic [7:0] tx_byte_i,
    output logic tx_req_o,
    output logic read_phase_o,
    output logic spi_mode_o,
    // Alarm events, flag clears and interrupt configuration.
    input wire logic alarm_a_event_i,
    input wire logic alarm_b_event_i,
    input wire logic alarm_a_clear_i,
    input wire logic alarm_b_clear_i,
    input wire logic irq_enable_a_i,
    input wire logic irq_enable_b_i,
    input wire logic irq_combine_sel_i,
    output logic alarm_flag_a_o,
    output logic alarm_flag_b_o,
    // Open-drain interrupt pins.
    output logic alarm_irq_a_n_o,
    output logic alarm_irq_a_n_oe_o,
    output logic alarm_irq_b_n_o,
    output logic alarm_irq_b_n_oe_o,
    // Supply comparator results and power-fail output.
    input wire logic primary_below_backup_i,
    input wire logic primary_below_battery_i,
    output logic power_fail_n_o,
    // Timekeeping source and seconds timebase.
    input wire logic osc_in_i,
    output logic seconds_tick_o,
    output logic [31:0] seconds_count_o
);

    rtcpi_pkg::rtcpi_pins_s pins_async;
    rtcpi_pkg::rtcpi_pins_s pins;
    logic sclk_rise;
    logic sclk_fall;
    logic osc_rise;

    // Every pin level passes two flip-flops before any logic reads it.
    always_comb begin
        pins_async = rtcpi_pkg::PINS_RESET;
        pins_async.chip_enable = chip_enable_i;
        pins_async.sclk = sclk_i;
        pins_async.data_in = serial_in_i;
        pins_async.below_backup = primary_below_backup_i;
        pins_async.below_battery = primary_below_battery_i;
        pins_async.osc = osc_in_i;
        pins_async.interface_select = interface_select_i;
    end

    rtcpi_sync #(
        .WIDTH($bits(rtcpi_pkg::rtcpi_pins_s))
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(pins_async),
        .sync_o(pins)
    );

    // Serial clock edges time every shift of the link.
    rtcpi_edge u_sclk_edge (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .level_i(pins.sclk),
        .rise_o(sclk_rise), // R8
        .fall_o(sclk_fall)
    );

    // Oscillator edges drive the timebase.
    rtcpi_edge u_osc_edge (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .level_i(pins.osc),
        .rise_o(osc_rise), // R10
        .fall_o()
    );

    // ------------------------------------------------------------------
    // Mode strap and power-fail output.
    logic spi_mode;
    logic next_spi_mode;
    logic power_fail_n;
    logic next_power_fail_n;
    rtcpi_pkg::rtcpi_state_e state;

    // The strap is only followed between transfers, so a change mid-frame is ignored.
    always_comb begin
        next_spi_mode = spi_mode;
        if (state == rtcpi_pkg::ST_IDLE && !pins.chip_enable) begin
            next_spi_mode = (pins.interface_select == rtcpi_pkg::MODE_SPI); // R4 R14
        end
        next_power_fail_n = ~(pins.below_backup | pins.below_battery); // R9
    end

    // Registers the strap and the power-fail level.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            spi_mode <= rtcpi_pkg::MODE_3WIRE;
            power_fail_n <= 1'b1;
        end else begin
            spi_mode <= next_spi_mode;
            power_fail_n <= next_power_fail_n;
        end
    end

    // ------------------------------------------------------------------
    // Serial transfer sequencer.
    rtcpi_pkg::rtcpi_state_e next_state;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] next_rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic [7:0] rx_byte;
    logic [7:0] next_rx_byte;
    logic rx_valid;
    logic next_rx_valid;
    logic rx_is_addr;
    logic next_rx_is_addr;
    logic serial_out;
    logic next_serial_out;
    logic serial_out_oe;
    logic next_serial_out_oe;
    logic tx_take;
    logic out_edge;
    logic [7:0] shifted_in;

    // SPI moves output bits on the rising edge, 3-wire on the falling edge.
    assign out_edge = spi_mode ? sclk_rise : sclk_fall; // R8
    assign shifted_in = rtcpi_pkg::rtcpi_shift_in(rx_shift, pins.data_in); // R6

    // Input bits are taken on rising edges; a byte ends on the eighth one.
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_rx_shift = rx_shift;
        next_tx_shift = tx_shift;
        next_rx_byte = rx_byte;
        next_rx_valid = 1'b0;
        next_rx_is_addr = rx_is_addr;
        next_serial_out = serial_out;
        tx_take = 1'b0;
        if (!pins.chip_enable) begin
            // Dropping chip enable ends the frame and drops a partial byte.
            next_state = rtcpi_pkg::ST_IDLE; // R5
            next_bit_cnt = rtcpi_pkg::BIT_FIRST;
        end else begin
            unique case (state)
                rtcpi_pkg::ST_IDLE: begin
                    next_state = rtcpi_pkg::ST_ADDR;
                    next_bit_cnt = rtcpi_pkg::BIT_FIRST;
                end
                rtcpi_pkg::ST_ADDR, rtcpi_pkg::ST_WRITE: begin
                    if (sclk_rise) begin
                        next_rx_shift = shifted_in; // R6
                        next_bit_cnt = bit_cnt + rtcpi_pkg::BIT_STEP;
                        if (bit_cnt == rtcpi_pkg::BIT_LAST) begin
                            next_rx_byte = shifted_in;
                            next_rx_valid = 1'b1;
                            next_rx_is_addr = (state == rtcpi_pkg::ST_ADDR);
                            if (state == rtcpi_pkg::ST_ADDR) begin
                                if (shifted_in[rtcpi_pkg::WRITE_FLAG_BIT]) begin
                                    next_state = rtcpi_pkg::ST_WRITE;
                                end else begin
                                    next_state = rtcpi_pkg::ST_READ; // R7
                                    next_tx_shift = tx_byte_i;
                                    tx_take = 1'b1;
                                end
                            end
                        end
                    end
                end
                rtcpi_pkg::ST_READ: begin
                    // The line carries our own data now, so input bits are not received.
                    if (out_edge) begin
                        next_serial_out = tx_shift[rtcpi_pkg::BYTE_W-1]; // R7
                        next_tx_shift = rtcpi_pkg::rtcpi_shift_in(tx_shift, 1'b0);
                    end
                    if (sclk_rise) begin
                        next_bit_cnt = bit_cnt + rtcpi_pkg::BIT_STEP;
                        if (bit_cnt == rtcpi_pkg::BIT_LAST) begin
                            // Burst reads fetch the next byte at each boundary.
                            next_tx_shift = tx_byte_i;
                            tx_take = 1'b1;
                        end
                    end
                end
                default: begin
                    next_state = rtcpi_pkg::ST_IDLE;
                    next_bit_cnt = rtcpi_pkg::BIT_FIRST;
                end
            endcase
        end
        next_serial_out_oe = (next_state == rtcpi_pkg::ST_READ); // R7
    end

    // Registers the sequencer.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= rtcpi_pkg::ST_IDLE;
            bit_cnt <= rtcpi_pkg::BIT_FIRST;
            rx_shift <= rtcpi_pkg::BYTE_RESET;
            tx_shift <= rtcpi_pkg::BYTE_RESET;
            rx_byte <= rtcpi_pkg::BYTE_RESET;
            rx_valid <= 1'b0;
            rx_is_addr <= 1'b0;
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            rx_shift <= next_rx_shift;
            tx_shift <= next_tx_shift;
            rx_byte <= next_rx_byte;
            rx_valid <= next_rx_valid;
            rx_is_addr <= next_rx_is_addr;
            serial_out <= next_serial_out;
            serial_out_oe <= next_serial_out_oe;
        end
    end

    // ------------------------------------------------------------------
    // Seconds timebase from the oscillator; no supply level gates it.
    logic [14:0] presc;
    logic [14:0] next_presc;
    logic [31:0] seconds;
    logic [31:0] next_seconds;
    logic tick;
    logic next_tick;

    // One second passes every 32768 oscillator rising edges.
    always_comb begin
        next_presc = presc;
        next_seconds = seconds;
        next_tick = 1'b0;
        if (osc_rise) begin
            if (presc == rtcpi_pkg::PRESC_LAST) begin
                next_presc = rtcpi_pkg::PRESC_RESET; // R10
                next_seconds = seconds + rtcpi_pkg::SECONDS_STEP; // R11
                next_tick = 1'b1;
            end else begin
                next_presc = presc + rtcpi_pkg::PRESC_STEP;
            end
        end
    end

    // Registers the timebase.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            presc <= rtcpi_pkg::PRESC_RESET;
            seconds <= rtcpi_pkg::SECONDS_RESET;
            tick <= 1'b0;
        end else begin
            presc <= next_presc;
            seconds <= next_seconds;
            tick <= next_tick;
        end
    end

    // ------------------------------------------------------------------
    // Alarm flags and interrupt pin drive.
    rtcpi_pkg::rtcpi_flags_s flags;
    rtcpi_pkg::rtcpi_flags_s next_flags;
    rtcpi_pkg::rtcpi_irq_s irq;
    rtcpi_pkg::rtcpi_irq_s next_irq;

    // A set arriving with a clear wins; the pins hold while flag and enable hold.
    always_comb begin
        next_flags.flag_a = alarm_a_event_i | (flags.flag_a & ~alarm_a_clear_i);
        next_flags.flag_b = alarm_b_event_i | (flags.flag_b & ~alarm_b_clear_i);
        next_irq.drive_a = (next_flags.flag_a & irq_enable_a_i)
                         | (irq_combine_sel_i & next_flags.flag_b & irq_enable_b_i); // R1 R3 R12
        next_irq.drive_b = ~irq_combine_sel_i & next_flags.flag_b & irq_enable_b_i; // R2 R3 R12
    end

    // Registers flags and drive enables; power fail does not stop them.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            flags <= '0;
            irq <= '0;
        end else begin
            flags <= next_flags;
            irq <= next_irq; // R11
        end
    end

    // ------------------------------------------------------------------
    // Output assignments.
    assign serial_out_o = serial_out;
    assign serial_out_oe_o = serial_out_oe;
    assign rx_byte_o = rx_byte;
    assign rx_valid_o = rx_valid;
    assign rx_is_addr_o = rx_is_addr;
    assign tx_req_o = tx_take;
    assign read_phase_o = (state == rtcpi_pkg::ST_READ);
    assign spi_mode_o = spi_mode;
    assign alarm_flag_a_o = flags.flag_a;
    assign alarm_flag_b_o = flags.flag_b;
    assign power_fail_n_o = power_fail_n;
    assign seconds_tick_o = tick;
    assign seconds_count_o = seconds;

    // Open-drain pins only ever pull low; released means enable low.
    assign alarm_irq_a_n_o = rtcpi_pkg::IRQ_DRIVE_LEVEL;
    assign alarm_irq_b_n_o = rtcpi_pkg::IRQ_DRIVE_LEVEL;
    assign alarm_irq_a_n_oe_o = irq.drive_a; // R13
    assign alarm_irq_b_n_oe_o = irq.drive_b; // R13

endmodule : rtcpi_top

// >>> testbench/rtcpi_checker.sv
// Concurrent checks on the ports of the RTC pin interface top level.
// Assumes a bind into rtcpi_top and clk_i as the only clock.
module rtcpi_checker (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Link and strap.
    input wire logic chip_enable_i,
    input wire logic interface_select_i,
    input wire logic serial_out_oe_o,
    input wire logic read_phase_o,
    input wire logic spi_mode_o,
    input wire logic rx_valid_o,
    // Alarms and interrupt pins.
    input wire logic alarm_a_event_i,
    input wire logic irq_enable_a_i,
    input wire logic irq_enable_b_i,
    input wire logic irq_combine_sel_i,
    input wire logic alarm_flag_a_o,
    input wire logic alarm_flag_b_o,
    input wire logic alarm_irq_a_n_o,
    input wire logic alarm_irq_a_n_oe_o,
    input wire logic alarm_irq_b_n_o,
    input wire logic alarm_irq_b_n_oe_o,
    // Supply and timebase.
    input wire logic primary_below_backup_i,
    input wire logic primary_below_battery_i,
    input wire logic power_fail_n_o,
    input wire logic seconds_tick_o,
    input wire logic [31:0] seconds_count_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Core clock; checks rest during reset.
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Interrupt pins are levels of flags, enables and combine select.
    property p_irq_a;
        $stable(irq_enable_a_i) && $stable(irq_enable_b_i) && $stable(irq_combine_sel_i)
            |-> alarm_irq_a_n_oe_o == (alarm_flag_a_o && irq_enable_a_i
                || irq_combine_sel_i && alarm_flag_b_o && irq_enable_b_i);
    endproperty
    a_irq_a: assert property (p_irq_a)
        else $error("pin A drive wrong");
    property p_irq_b;
        $stable(irq_enable_b_i) && $stable(irq_combine_sel_i)
            |-> alarm_irq_b_n_oe_o == (!irq_combine_sel_i && alarm_flag_b_o && irq_enable_b_i);
    endproperty
    a_irq_b: assert property (p_irq_b)
        else $error("pin B drive wrong");
    property p_drive;
        {alarm_irq_a_n_o, alarm_irq_b_n_o} == 2'h0
            && (alarm_flag_a_o || alarm_flag_b_o || !alarm_irq_a_n_oe_o && !alarm_irq_b_n_oe_o);
    endproperty
    a_drive: assert property (p_drive)
        else $error("pin drive illegal");
    property p_flag_set;
        alarm_a_event_i |=> alarm_flag_a_o;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("alarm A flag not set");

    // Power fail follows the supply comparison.
    property p_pf_fall;
        $rose(primary_below_backup_i || primary_below_battery_i) |-> ##[1:4] !power_fail_n_o;
    endproperty
    a_pf_fall: assert property (p_pf_fall)
        else $error("power fail late");
    property p_pf_rise;
        (!primary_below_backup_i && !primary_below_battery_i)[*5] |-> power_fail_n_o;
    endproperty
    a_pf_rise: assert property (p_pf_rise)
        else $error("power fail stuck");

    // Data out is driven only in a read phase.
    property p_oe_ce;
        (!chip_enable_i)[*6] |-> !serial_out_oe_o;
    endproperty
    a_oe_ce: assert property (p_oe_ce)
        else $error("data out on idle");
    property p_oe_read;
        serial_out_oe_o |-> read_phase_o;
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("data out off read");
    property p_rx_pulse;
        rx_valid_o |=> !rx_valid_o;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse)
        else $error("byte strobe too long");

    // The seconds count moves only with its tick.
    property p_tick_hold;
        !seconds_tick_o |-> $stable(seconds_count_o);
    endproperty
    a_tick_hold: assert property (p_tick_hold)
        else $error("seconds moved without tick");

    // While idle the mode follows a steady strap.
    property p_strap;
        (!chip_enable_i && $stable(interface_select_i))[*6] |-> spi_mode_o == interface_select_i;
    endproperty
    a_strap: assert property (p_strap)
        else $error("mode not strap");
endmodule : rtcpi_checker

bind rtcpi_top rtcpi_checker u_chk (
    .clk_i, .reset_i, .chip_enable_i, .interface_select_i, .serial_out_oe_o, .read_phase_o,
    .spi_mode_o, .rx_valid_o, .alarm_a_event_i, .irq_enable_a_i, .irq_enable_b_i,
    .irq_combine_sel_i, .alarm_flag_a_o, .alarm_flag_b_o, .alarm_irq_a_n_o,
    .alarm_irq_a_n_oe_o, .alarm_irq_b_n_o, .alarm_irq_b_n_oe_o, .primary_below_backup_i,
    .primary_below_battery_i, .power_fail_n_o, .seconds_tick_o, .seconds_count_o
);

// >>> testbench/rtcpi_host_model.sv
// Host serial master: 800 ns serial clock, MSB first.
// Assumes the bench joins data in and data out on one line in 3-wire mode.
module rtcpi_host_model (
    // Link pins driven by the host.
    output logic ce_o,
    output logic sclk_o,
    output logic data_o,
    // Data line as seen, and the mode.
    input wire logic line_i,
    input wire logic spi_i
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pins start low; chip enable and serial clock rest low between frames, so the serial clock stands still.
    initial begin
        ce_o = 1'b0;
        sclk_o = 1'b0;
        data_o = 1'b0;
    end

    // Chip enable spans the transfer, with settling room each side.
    task automatic frame(input logic on);
        ce_o = on;
        #1000;
    endtask : frame

    // Sends n bits of tx; drive low sends toggling filler bits instead while read data comes back.
    task automatic xfer(input logic [7:0] tx, input logic drive, input int n,
                        output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            data_o = drive ? tx[i] : ~data_o;
            #200 sclk_o = 1'b1;
            #200 if (!spi_i) rx[i] = line_i;
            #200 sclk_o = 1'b0;
            #200 if (spi_i) rx[i] = line_i;
        end
    endtask : xfer
endmodule : rtcpi_host_model

// >>> testbench/tb_top.sv
// Self-checking bench for rtcpi_top.
// Assumes rtcpi_checker is bound in and the host model drives the link pins.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i, reset_i, ce, sclk, hdata, sel, sin, sout, oe, osc;
    logic ev_a, ev_b, clr_a, clr_b, en_a, en_b, comb, bb, bat;
    logic rx_valid, rx_addr, tx_req, rd_ph, spi, fl_a, fl_b, ia, ia_oe, ib, ib_oe, pf, tick;
    logic [7:0] rx_byte;
    logic [31:0] secs;
    logic [1:0] ntx = 2'h0;
    logic [7:0] txv [4] = '{8'hC3, 8'h5A, 8'h96, 8'h3C};
    logic [8:0] rxq [$];
    int n_mismatch = 0;
    int checked = 0;

    // 3-wire: data out joins data in while the device drives.
    assign sin = (sel || !oe) ? hdata : sout;

    rtcpi_top u_dut (
        .clk_i(clk_i), .reset_i(reset_i), .chip_enable_i(ce), .sclk_i(sclk),
        .serial_in_i(sin), .serial_out_o(sout), .serial_out_oe_o(oe),
        .interface_select_i(sel), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
        .rx_is_addr_o(rx_addr), .tx_byte_i(txv[ntx]), .tx_req_o(tx_req),
        .read_phase_o(rd_ph), .spi_mode_o(spi), .alarm_a_event_i(ev_a),
        .alarm_b_event_i(ev_b), .alarm_a_clear_i(clr_a), .alarm_b_clear_i(clr_b),
        .irq_enable_a_i(en_a), .irq_enable_b_i(en_b), .irq_combine_sel_i(comb),
        .alarm_flag_a_o(fl_a), .alarm_flag_b_o(fl_b), .alarm_irq_a_n_o(ia),
        .alarm_irq_a_n_oe_o(ia_oe), .alarm_irq_b_n_o(ib), .alarm_irq_b_n_oe_o(ib_oe),
        .primary_below_backup_i(bb), .primary_below_battery_i(bat), .power_fail_n_o(pf),
        .osc_in_i(osc), .seconds_tick_o(tick), .seconds_count_o(secs)
    );

    rtcpi_host_model u_host (
        .ce_o(ce), .sclk_o(sclk), .data_o(hdata), .line_i(sel ? sout : sin), .spi_i(sel)
    );

    // Core clock at 10 MHz and a free-running timekeeping source.
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        osc = 1'b0;
        forever #200 osc = ~osc;
    end

    // Logs received bytes; steps the read data table per request.
    always @(posedge clk_i) begin
        if (rx_valid) rxq.push_back({rx_addr, rx_byte});
        if (tx_req) ntx <= ntx + 2'h1;
    end

    // Compares one value; reports a mismatch.
    task automatic check(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Waits n edges and lets their updates land.
    task automatic clks(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : clks

    // Prints counts and verdict, then ends the run.
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // Frame: address, then a write plus a cut byte, or two reads.
    task automatic run_frame(input logic mode, input logic [7:0] addr, input logic [7:0] wd);
        logic [7:0] rd;
        logic [1:0] base;
        @(posedge clk_i);
        sel <= mode;
        clks(6);
        check("mode", spi, mode);
        rxq.delete();
        base = ntx;
        #37;
        u_host.frame(1'b1);
        u_host.xfer(addr, 1'b1, 8, rd);
        if (addr[7]) begin
            u_host.xfer(wd, 1'b1, 8, rd);
            u_host.xfer(~wd, 1'b1, 5, rd);
        end else begin
            u_host.xfer(8'h00, 1'b0, 8, rd);
            check("read 0", rd, txv[base]);
            u_host.xfer(8'h00, 1'b0, 8, rd);
            check("read 1", rd, txv[base + 2'h1]);
        end
        u_host.frame(1'b0);
        check("byte count", rxq.size(), addr[7] ? 2 : 1);
        check("address", rxq[0], {1'b1, addr});
        if (addr[7]) check("data", rxq[1], {1'b0, wd});
    endtask : run_frame

    // Watchdog at about 30 times the expected run.
    initial begin
        #3000000;
        n_mismatch++;
        test_done();
    end

    // Main sequence.
    initial begin
        {ev_a, ev_b, clr_a, clr_b, en_a, en_b, comb, bb, bat} = '0;
        sel = 1'b1;
        reset_i = 1'b1;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        clks(1);
        check("reset pins", {pf, oe, ia_oe, ib_oe, fl_a, fl_b}, 6'h20);
        for (int c = 0; c < 2; c++) begin
            for (int w = 0; w < 2; w++) begin
                @(posedge clk_i);
                {comb, en_a, en_b, ev_a, ev_b} <= {c[0], 2'h3, w == 0, w == 1};
                @(posedge clk_i);
                {ev_a, ev_b} <= 2'h0;
                clks(3);
                check("irq a", ia_oe, w == 0 || c == 1);
                check("irq b", ib_oe, w == 1 && c == 0);
                clks(20);
                check("irq hold", {ia_oe, ib_oe}, {w == 0 || c == 1, w == 1 && c == 0});
                @(posedge clk_i);
                {en_a, en_b} <= 2'h0;
                clks(3);
                check("irq off", {ia_oe, ib_oe, fl_a, fl_b}, {2'h0, w == 0, w == 1});
                @(posedge clk_i);
                {en_a, en_b, clr_a, clr_b} <= 4'hF;
                @(posedge clk_i);
                {clr_a, clr_b} <= 2'h0;
                clks(3);
                check("irq clear", {ia_oe, ib_oe, fl_a, fl_b}, 4'h0);
            end
        end
        for (int k = 1; k < 5; k++) begin
            @(posedge clk_i);
            {bat, bb} <= k[1:0];
            clks(6);
            check("power fail", pf, k[1:0] == 2'h0);
        end
        run_frame(1'b1, 8'h85, 8'hA6);
        run_frame(1'b1, 8'h0A, 8'h00);
        run_frame(1'b0, 8'hC1, 8'h5B);
        run_frame(1'b0, 8'h11, 8'h00);
        check("seconds", {tick, secs}, 33'h0);
        test_done();
    end
endmodule : tb_top
